// File: logic/acs_map.vh
// register map, field positions, reset values and timing counts
`ifndef ACS_MAP_VH
`define ACS_MAP_VH

// ****************************************
// register byte offsets
// ****************************************
`define ACS_CTRL_OFS      4'h0
`define ACS_SEL_OFS       4'h4
`define ACS_RESULT_OFS    4'h8
`define ACS_STATUS_OFS    4'hC

// ****************************************
// control register fields
// ****************************************
`define ACS_CTRL_EN       7
`define ACS_CTRL_START    6
`define ACS_CTRL_FREE     5
`define ACS_CTRL_DONE     4
`define ACS_CTRL_IE       3
`define ACS_CTRL_DIV_HI   2
`define ACS_CTRL_DIV_LO   0

// ****************************************
// selection register fields
// ****************************************
`define ACS_SEL_REF_HI    7
`define ACS_SEL_REF_LO    6
`define ACS_SEL_CH_HI     3
`define ACS_SEL_CH_LO     0

// ****************************************
// reset values
// ****************************************
`define ACS_SEL_RST       6'h00
`define ACS_DIV_RST       3'h0
`define ACS_RESULT_RST    10'h000

// ****************************************
// conversion timing, in converter clock cycles
// ****************************************
`define ACS_NORM_LEN      5'd13
`define ACS_EXT_LEN       5'd25
`define ACS_NORM_SH       5'd1
`define ACS_EXT_SH        5'd13
`define ACS_SAR_BITS      5'd10

// ****************************************
// sleep mode codes seen on sleep_mode_i
// ****************************************
`define ACS_SLEEP_IDLE    3'h0
`define ACS_SLEEP_NR      3'h1

`endif

// File: logic/acs_prescaler.v
// converter clock prescaler producing rise and mid-cycle ticks
`timescale 1ns/1ps
module acs_prescaler (
  input  wire       ref_clk_i,
  input  wire       nrst_i,
  input  wire       ce_i,
  input  wire       enable_i,
  input  wire [2:0] div_sel_i,
  output wire       rise_o,
  output wire       fall_o
);

  reg  [6:0] cnt;
  wire [2:0] expo;
  wire [7:0] mask;
  wire [7:0] low;

  // divide by 2^sel, with sel 0 treated as divide by two
  assign expo = (div_sel_i == 3'h0) ? 3'h1 : div_sel_i;
  assign mask = (8'h01 << expo) - 8'h01;
  assign low  = {1'b0, cnt} & mask;

  assign rise_o = enable_i & (low == mask);
  assign fall_o = enable_i & (low == {1'b0, mask[7:1]});

  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      cnt <= 7'h00;
    end else if (ce_i) begin
      if (!enable_i) begin
        cnt <= 7'h00;
      end else begin
        cnt <= cnt + 7'h01;
      end
    end
  end

endmodule // acs_prescaler

// File: logic/acs_sar.v
// successive approximation register, one bit decided per step
`timescale 1ns/1ps
module acs_sar (
  input  wire       ref_clk_i,
  input  wire       nrst_i,
  input  wire       ce_i,
  input  wire       load_i,
  input  wire       step_i,
  input  wire       cmp_i,
  output reg  [9:0] code_o
);

  reg  [9:0] trial;
  wire [9:0] kept;
  wire [9:0] next_trial;

  // comparator high means input at or above the trial code
  assign kept       = cmp_i ? code_o : (code_o & ~trial);
  assign next_trial = {1'b0, trial[9:1]};

  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      code_o <= 10'h000;
      trial  <= 10'h000;
    end else if (ce_i) begin
      if (load_i) begin
        code_o <= 10'h200;
        trial  <= 10'h200;
      end else if (step_i && (trial != 10'h000)) begin
        code_o <= kept | next_trial;
        trial  <= next_trial;
      end
    end
  end

endmodule // acs_sar

// File: logic/acs_sequencer.v
// converter conversion sequencer with avalon register slave
`timescale 1ns/1ps
`include "acs_map.vh"

// Contract
// - prescaler counts while enabled and is held in reset while disabled.
// - a set start bit begins conversion on the next converter clock rise.
// - an ordinary conversion lasts 13 converter clock cycles.
// - the first conversion after enabling lasts 25 converter clock cycles.
// - sample strobe at 1.5 cycles, or 13.5 cycles in the first conversion.
// - completion writes the result and sets the done flag.
// - in single mode the start bit clears together with the done flag.
// - free running restarts immediately and keeps the start bit high.
// - channel and reference pass a holding register, locked during conversion.
// - selection transfer resumes in the last cycle before completion.
// - in free running a post-completion selection change skips the next conversion.
// - idle or noise-reduction sleep with halted cpu starts a conversion when not busy, with the interrupt enabled and free running off.
// - a sleep conversion finishes and raises its request even after wake-up.
// - other sleep modes leave the converter enable untouched.
// - clearing the enable aborts a running conversion at once.
// - a channel change during conversion applies only from its last cycle.
module acs_sequencer (
  input  wire        ref_clk_i,
  input  wire        nrst_i,
  input  wire        ce_i,
  input  wire [3:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output reg  [31:0] avs_readdata_o,
  output wire        avs_waitrequest_o,
  input  wire        cmp_i,
  input  wire [2:0]  sleep_mode_i,
  input  wire        cpu_halted_i,
  output reg         sh_strobe_o,
  output wire [9:0]  dac_code_o,
  output reg  [3:0]  active_channel_o,
  output reg  [1:0]  active_ref_o,
  output wire        analog_enable_o,
  output wire        conv_active_o,
  output wire        done_irq_o
);

  // ****************************************
  // address decode
  // ****************************************
  function hit;
    input [3:0] addr;
    input [3:0] ofs;
    begin
      hit = (addr[3:2] == ofs[3:2]);
    end
  endfunction

  // ****************************************
  // state
  // ****************************************
  reg        converter_enable;
  reg        start_conversion_bit;
  reg        free_run_select;
  reg        conversion_done_flag;
  reg        irq_enable;
  reg  [2:0] clock_divide_select;
  reg  [3:0] channel_select;
  reg  [1:0] reference_select;
  reg  [9:0] result;
  reg        busy;
  reg        extended;
  reg        first_pending;
  reg  [4:0] cyc;
  reg        ack;
  reg        cmp_meta;
  reg        cmp_sync;
  reg        halted_q;

  wire       rise;
  wire       fall;
  wire [9:0] sar_code;
  wire       access;
  wire       wr_ctrl;
  wire       wr_sel;
  wire [7:0] wbyte;
  wire [4:0] conv_len;
  wire [4:0] sh_cyc;
  wire       last_cyc;
  wire       complete;
  wire       begin_conv;
  wire       sh_now;
  wire       sar_step;
  wire       sleep_ok;
  wire       sleep_start;
  wire       sw_start;
  wire       sw_clear_done;
  wire       en_next;

  // ****************************************
  // avalon slave handshake
  // ****************************************
  // one wait state per access keeps read data registered
  assign access            = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = access & ~ack;

  assign wbyte   = avs_writedata_i[7:0];
  assign wr_ctrl = avs_write_i & ack & avs_byteenable_i[0]
                   & hit(avs_address_i, `ACS_CTRL_OFS);
  assign wr_sel  = avs_write_i & ack & avs_byteenable_i[0]
                   & hit(avs_address_i, `ACS_SEL_OFS);

  assign sw_start      = wr_ctrl & wbyte[`ACS_CTRL_START];
  assign sw_clear_done = wr_ctrl & wbyte[`ACS_CTRL_DONE];

  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      ack            <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      ack <= access & ~ack;
      if (avs_read_i && !ack) begin
        if (hit(avs_address_i, `ACS_CTRL_OFS)) begin
          avs_readdata_o <= {24'h00_0000, converter_enable,
                             start_conversion_bit, free_run_select,
                             conversion_done_flag, irq_enable,
                             clock_divide_select};
        end else if (hit(avs_address_i, `ACS_SEL_OFS)) begin
          avs_readdata_o <= {24'h00_0000, reference_select, 2'b00,
                             channel_select};
        end else if (hit(avs_address_i, `ACS_RESULT_OFS)) begin
          avs_readdata_o <= {22'h00_0000, result};
        end else begin
          // busy 15, extended 14, first 13, ref 12:11, channel 10:7, cycle 4:0
          avs_readdata_o <= {16'h0000, busy, extended,
                             first_pending, active_ref_o,
                             active_channel_o, 2'b00, cyc};
        end
      end
    end
  end

  // ****************************************
  // comparator synchroniser
  // ****************************************
  // two flops of latency: a step reads a fresh decision only when the
  // converter clock is at least four system clocks long, since the first step comes one and a half cycles after the load
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
    end else if (ce_i) begin
      cmp_meta <= cmp_i;
      cmp_sync <= cmp_meta;
    end
  end

  // ****************************************
  // prescaler and approximation register
  // ****************************************
  acs_prescaler u_prescaler (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .ce_i      (ce_i),
    .enable_i  (converter_enable),
    .div_sel_i (clock_divide_select),
    .rise_o    (rise),
    .fall_o    (fall)
  );

  acs_sar u_sar (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .ce_i      (ce_i),
    .load_i    (sh_now),
    .step_i    (sar_step),
    .cmp_i     (cmp_sync),
    .code_o    (sar_code)
  );

  assign dac_code_o = sar_code;

  // ****************************************
  // conversion timing
  // ****************************************
  assign conv_len = extended ? `ACS_EXT_LEN : `ACS_NORM_LEN;
  assign sh_cyc   = extended ? `ACS_EXT_SH : `ACS_NORM_SH;
  assign last_cyc = busy & (cyc == conv_len - 5'd1);
  assign complete = last_cyc & rise;

  // start waits for a converter clock rise, never mid-cycle
  assign begin_conv = converter_enable & rise & start_conversion_bit
                      & ~busy;

  // strobe half a cycle into cycle 1, or into cycle 13 when extended
  assign sh_now   = busy & fall & (cyc == sh_cyc);
  assign sar_step = busy & rise & (cyc > sh_cyc)
                    & (cyc <= sh_cyc + `ACS_SAR_BITS);

  // ****************************************
  // sleep-initiated conversion
  // ****************************************
  // only idle and noise-reduction sleep qualify; others change nothing
  assign sleep_ok = (sleep_mode_i == `ACS_SLEEP_IDLE)
                    | (sleep_mode_i == `ACS_SLEEP_NR);

  assign sleep_start = converter_enable & ~busy & ~start_conversion_bit
                       & ~free_run_select & irq_enable & sleep_ok
                       & cpu_halted_i & ~halted_q;

  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      halted_q <= 1'b0;
    end else if (ce_i) begin
      halted_q <= cpu_halted_i;
    end
  end

  // ****************************************
  // control bits
  // ****************************************
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      converter_enable    <= 1'b0;
      free_run_select     <= 1'b0;
      irq_enable          <= 1'b0;
      clock_divide_select <= `ACS_DIV_RST;
    end else if (ce_i && wr_ctrl) begin
      converter_enable    <= wbyte[`ACS_CTRL_EN];
      free_run_select     <= wbyte[`ACS_CTRL_FREE];
      irq_enable          <= wbyte[`ACS_CTRL_IE];
      clock_divide_select <= wbyte[`ACS_CTRL_DIV_HI:`ACS_CTRL_DIV_LO];
    end
  end

  // enable as it will be after this edge, so enable and start may be
  // written together and a disabling write clears start at once
  assign en_next = wr_ctrl ? wbyte[`ACS_CTRL_EN] : converter_enable;

  // writing zero to the start bit has no effect; only completion in single mode or a disabling write clears it
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      start_conversion_bit <= 1'b0;
    end else if (ce_i) begin
      if (!en_next) begin
        start_conversion_bit <= 1'b0;
      end else if (sw_start || sleep_start) begin
        start_conversion_bit <= 1'b1;
      end else if (complete && !free_run_select) begin
        start_conversion_bit <= 1'b0;
      end
    end
  end

  // set wins over a write-one clear in the same cycle
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      conversion_done_flag <= 1'b0;
    end else if (ce_i) begin
      if (complete) begin
        conversion_done_flag <= 1'b1;
      end else if (sw_clear_done) begin
        conversion_done_flag <= 1'b0;
      end
    end
  end

  // request stays up after wake-up until software clears the flag
  assign done_irq_o = conversion_done_flag & irq_enable;

  // ****************************************
  // selection holding and active selection
  // ****************************************
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      {reference_select, channel_select} <= `ACS_SEL_RST;
    end else if (ce_i && wr_sel) begin
      reference_select <= wbyte[`ACS_SEL_REF_HI:`ACS_SEL_REF_LO];
      channel_select   <= wbyte[`ACS_SEL_CH_HI:`ACS_SEL_CH_LO];
    end
  end

  // selections take effect only while enabled, and are frozen mid-conversion
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      {active_ref_o, active_channel_o} <= `ACS_SEL_RST;
    end else if (ce_i && converter_enable) begin
      if (!busy || last_cyc) begin
        active_ref_o     <= reference_select;
        active_channel_o <= channel_select;
      end
    end
  end

  // ****************************************
  // conversion sequencer
  // ****************************************
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      busy          <= 1'b0;
      extended      <= 1'b0;
      first_pending <= 1'b1;
      cyc           <= 5'd0;
    end else if (ce_i) begin
      if (!converter_enable) begin
        busy          <= 1'b0;
        cyc           <= 5'd0;
        first_pending <= 1'b1;
      end else if (begin_conv) begin
        busy          <= 1'b1;
        cyc           <= 5'd0;
        extended      <= first_pending;
        first_pending <= 1'b0;
      end else if (complete) begin
        cyc      <= 5'd0;
        extended <= 1'b0;
        // free running restarts on this same rise, start bit untouched
        busy     <= free_run_select & start_conversion_bit;
      end else if (busy && rise) begin
        cyc <= cyc + 5'd1;
      end
    end
  end

  // ****************************************
  // result and sample strobe
  // ****************************************
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      result      <= `ACS_RESULT_RST;
      sh_strobe_o <= 1'b0;
    end else if (ce_i) begin
      // no strobe on the edge that switches the converter off
      sh_strobe_o <= sh_now & en_next;
      if (complete) begin
        result <= sar_code;
      end
    end
  end

  assign analog_enable_o = converter_enable;
  assign conv_active_o   = busy;

endmodule // acs_sequencer

// File: tb/acs_seq_props.sv
// concurrent checks on the conversion sequencer ports
`timescale 1ns/1ps
module acs_seq_props (
  input wire        ref_clk_i,
  input wire        nrst_i,
  input wire        ce_i,
  input wire [3:0]  avs_address_i,
  input wire        avs_read_i,
  input wire        avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0]  avs_byteenable_i,
  input wire [31:0] avs_readdata_o,
  input wire        avs_waitrequest_o,
  input wire        cmp_i,
  input wire [2:0]  sleep_mode_i,
  input wire        cpu_halted_i,
  input wire        sh_strobe_o,
  input wire [9:0]  dac_code_o,
  input wire [3:0]  active_channel_o,
  input wire [1:0]  active_ref_o,
  input wire        analog_enable_o,
  input wire        conv_active_o,
  input wire        done_irq_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  property p_one_wait;
    (avs_read_i || avs_write_i) && avs_waitrequest_o && ce_i |=> !avs_waitrequest_o;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("bus cycle waits too long");
  property p_wait_req;
    avs_waitrequest_o |-> (avs_read_i || avs_write_i);
  endproperty
  a_wait_req: assert property (p_wait_req) else $error("wait without request");
  property p_sh_pulse;
    sh_strobe_o |=> !sh_strobe_o;
  endproperty
  a_sh_pulse: assert property (p_sh_pulse) else $error("strobe too long");
  property p_sh_busy;
    sh_strobe_o |-> conv_active_o && analog_enable_o;
  endproperty
  a_sh_busy: assert property (p_sh_busy) else $error("strobe while idle");
  property p_sh_due;
    $rose(conv_active_o) |-> ##[1:200] (sh_strobe_o || !analog_enable_o);
  endproperty
  a_sh_due: assert property (p_sh_due) else $error("no strobe in conversion");
  property p_abort;
    !analog_enable_o ##1 !analog_enable_o |-> !conv_active_o;
  endproperty
  a_abort: assert property (p_abort) else $error("busy while disabled");
  property p_lock;
    $rose(conv_active_o) |=> ($stable(active_channel_o) && $stable(active_ref_o)) [*8];
  endproperty
  a_lock: assert property (p_lock) else $error("selection moved");
  property p_done_end;
    $rose(done_irq_o) |-> $past(conv_active_o);
  endproperty
  a_done_end: assert property (p_done_end) else $error("done without conversion");

  c_sh: cover property (sh_strobe_o);
  c_done: cover property ($rose(done_irq_o));
  c_abort: cover property ($fell(analog_enable_o) && conv_active_o);
endmodule // acs_seq_props

// File: tb/acs_analog_model.sv
// behavioural analog core: sample-and-hold plus comparator
`timescale 1ns/1ps
module acs_analog_model (
  input  wire       ref_clk_i,
  input  wire       sh_strobe_i,
  input  wire [3:0] channel_i,
  input  wire [9:0] dac_code_i,
  output wire       cmp_o
);
  // distinct level per channel, so a wrong mux shows in the result
  reg [9:0] held = 10'h000;
  always @(posedge ref_clk_i) begin
    if (sh_strobe_i) begin
      held <= {channel_i, 6'h15};
    end
  end
  assign cmp_o = held >= dac_code_i;
endmodule // acs_analog_model

// File: tb/tb_top.sv
// testbench for the conversion sequencer
`timescale 1ns/1ps
`include "acs_map.vh"
module tb_top;
  localparam logic [31:0] EN    = 32'h0000_0001 << `ACS_CTRL_EN;
  localparam logic [31:0] START = 32'h0000_0001 << `ACS_CTRL_START;
  localparam logic [31:0] FREE  = 32'h0000_0001 << `ACS_CTRL_FREE;
  localparam logic [31:0] DONE  = 32'h0000_0001 << `ACS_CTRL_DONE;
  localparam logic [31:0] IE    = 32'h0000_0001 << `ACS_CTRL_IE;
  reg          ref_clk_i = 1'b0;
  reg          nrst_i    = 1'b0;
  reg          rd        = 1'b0;
  reg          wr        = 1'b0;
  reg          halted    = 1'b0;
  reg  [3:0]   addr      = 4'h0;
  reg  [31:0]  wdata     = 32'h0000_0000;
  reg  [2:0]   smode     = 3'h0;
  wire [31:0]  rdata;
  wire         waitreq, cmp, sh, aen, busy, irq;
  wire [9:0]   dac;
  wire [3:0]   ach;
  wire [1:0]   aref;
  logic [31:0] q;
  int          fail_count = 0;
  int          n_checks   = 0;
  int          cnt = 0, last_dur = 0, last_sh = 0, n_sh = 0;

  always #10 ref_clk_i = ~ref_clk_i;

  acs_sequencer dut (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ce_i(1'b1), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .cmp_i(cmp),
    .sleep_mode_i(smode), .cpu_halted_i(halted), .sh_strobe_o(sh), .dac_code_o(dac),
    .active_channel_o(ach), .active_ref_o(aref), .analog_enable_o(aen),
    .conv_active_o(busy), .done_irq_o(irq));
  acs_analog_model u_core (
    .ref_clk_i(ref_clk_i), .sh_strobe_i(sh), .channel_i(ach), .dac_code_i(dac), .cmp_o(cmp));

  // ****
  // conversion length and strobe offset, in system clocks
  // ****
  always @(posedge ref_clk_i) begin
    if (sh === 1'b1) begin
      n_sh <= n_sh + 1;
    end
    if (busy === 1'b1) begin
      cnt <= cnt + 1;
      if (sh === 1'b1) begin
        last_sh <= cnt;
      end
    end else if (cnt != 0) begin
      last_dur <= cnt;
      cnt <= 0;
    end
  end

  // ****
  // shared tasks
  // ****
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (waitreq !== 1'b0 && n < 100);
    if (n >= 100) fail_count++;
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic settle;
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 200) begin
      @(posedge ref_clk_i);
      n++;
    end
    if (busy !== 1'b1) fail_count++;
    while (busy === 1'b1 && n < 2000) begin
      @(posedge ref_clk_i);
      n++;
    end
    if (busy === 1'b1) fail_count++;
    repeat (2) @(posedge ref_clk_i);
  endtask
  function automatic logic [31:0] res(input logic [3:0] ch);
    return {22'h0, ch, 6'h15};
  endfunction
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ****
  // scenarios
  // ****
  task automatic t_reset;
    bus(1'b0, `ACS_CTRL_OFS, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, `ACS_SEL_OFS, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, `ACS_RESULT_OFS, 32'h0);
    chk(q, 32'h0);
    chk({22'h0, sh, busy, aen, irq, ach, aref}, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_first;
    int ext_sh;
    bus(1'b1, `ACS_SEL_OFS, 32'h0000_0003);
    // divide by eight: short run, yet every decision settles
    bus(1'b1, `ACS_CTRL_OFS, EN | START | 32'h0000_0003);
    settle;
    chk(last_dur, 32'd200);
    ext_sh = last_sh;
    bus(1'b0, `ACS_RESULT_OFS, 32'h0);
    chk(q, res(4'h3));
    bus(1'b0, `ACS_CTRL_OFS, 32'h0);
    chk(q & (START | DONE), DONE);
    bus(1'b1, `ACS_CTRL_OFS, EN | START | 32'h0000_0003);
    settle;
    chk(last_dur, 32'd104);
    chk(ext_sh - last_sh, 32'd96);
    $display("test first done");
  endtask
  task automatic t_div;
    bus(1'b1, `ACS_SEL_OFS, 32'h0000_0045);
    bus(1'b1, `ACS_CTRL_OFS, EN | DONE | START | 32'h0000_0004);
    repeat (16) @(posedge ref_clk_i);
    bus(1'b1, `ACS_SEL_OFS, 32'h0000_0089);
    chk({26'h0, ach, aref}, 32'h0000_0015);
    settle;
    chk(last_dur, 32'd208);
    bus(1'b0, `ACS_RESULT_OFS, 32'h0);
    chk(q, res(4'h5));
    chk({26'h0, ach, aref}, 32'h0000_0026);
    $display("test divider done");
  endtask
  task automatic t_free;
    int lows, n0;
    bus(1'b1, `ACS_SEL_OFS, 32'h0000_0002);
    bus(1'b1, `ACS_CTRL_OFS, EN | DONE | START | FREE | 32'h0000_0003);
    repeat (10) @(posedge ref_clk_i);
    lows = 0;
    n0 = n_sh;
    repeat (460) begin
      @(posedge ref_clk_i);
      if (busy !== 1'b1) lows++;
    end
    chk(lows, 32'd0);
    chk(n_sh - n0 >= 4, 32'h1);
    bus(1'b0, `ACS_CTRL_OFS, 32'h0);
    chk(q & START, START);
    bus(1'b0, `ACS_RESULT_OFS, 32'h0);
    chk(q, res(4'h2));
    bus(1'b1, `ACS_CTRL_OFS, 32'h0);
    repeat (2) @(posedge ref_clk_i);
    chk({30'h0, aen, busy}, 32'h0);
    bus(1'b1, `ACS_CTRL_OFS, EN | START);
    settle;
    chk(last_dur, 32'd50);
    $display("test free run done");
  endtask
  task automatic t_sleep;
    int n;
    for (int m = 0; m < 2; m++) begin
      bus(1'b1, `ACS_CTRL_OFS, EN | DONE | IE);
      smode <= 3'(m);
      halted <= 1'b1;
      n = 0;
      while (busy !== 1'b1 && n < 100) begin
        @(posedge ref_clk_i);
        n++;
      end
      halted <= 1'b0;
      settle;
      chk({31'h0, irq}, 32'h1);
    end
    bus(1'b1, `ACS_CTRL_OFS, EN | DONE | IE);
    smode <= 3'h2;
    halted <= 1'b1;
    repeat (40) @(posedge ref_clk_i);
    chk({30'h0, aen, busy}, 32'h2);
    halted <= 1'b0;
    $display("test sleep done");
  endtask

  initial begin
    repeat (8) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    t_reset;
    t_first;
    t_div;
    t_free;
    t_sleep;
    summarize;
  end
  initial begin
    repeat (50000) @(posedge ref_clk_i);
    fail_count++;
    summarize;
  end
endmodule // tb_top

bind acs_sequencer acs_seq_props u_props (
  .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .cmp_i(cmp_i), .sleep_mode_i(sleep_mode_i),
  .cpu_halted_i(cpu_halted_i), .sh_strobe_o(sh_strobe_o), .dac_code_o(dac_code_o),
  .active_channel_o(active_channel_o), .active_ref_o(active_ref_o),
  .analog_enable_o(analog_enable_o), .conv_active_o(conv_active_o), .done_irq_o(done_irq_o));
